// ==== common/piu_pkg.sv ====
// Shared constants and types of the priority interrupt unit
package piu_pkg;
    localparam int NUM_IRQ = 5;
    localparam int STACK_DEPTH = 5;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int LVL_W = 3;
    localparam int SP_W = 3;
    localparam int NUM_EV = 3;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_ACTIVE = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_MASK = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_PORTC = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_IMASK = 3'h5;

    // Control register fields and the port C request bit
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_PRIO_BIT = 1;
    localparam int CTRL_EDGE3_BIT = 2;
    localparam int CTRL_EDGE4_BIT = 3;
    localparam int PORTC_REQ_BIT = 5;

    // Event bits of the interrupt status register
    localparam int EV_LOAD = 0;
    localparam int EV_OVERFLOW = 1;
    localparam int EV_UNDERFLOW = 2;

    // Reset values
    localparam logic [NUM_IRQ-1:0] MASK_RST = 5'h00;
    localparam logic [NUM_EV-1:0] IMASK_RST = 3'h0;
    localparam logic [LVL_W-1:0] LVL_NONE = 3'h0;

    typedef struct packed {
        logic edge_select_four;
        logic edge_select_three;
        logic priority_select;
        logic port_c_interrupt_mode;
    } piu_ctrl_t;

    localparam piu_ctrl_t CTRL_RST = 4'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } piu_bus_req_t;
endpackage

// ==== rtl/piu_edge_detect.sv ====
// Input synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none
module piu_edge_detect #(
    parameter int N = 5
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Pins and edge choice
    input wire logic [N-1:0] pins,
    input wire logic [N-1:0] rise_sel,
    // Detected edges, one cycle each
    output logic [N-1:0] edges
);
    logic [N-1:0] s1_q, s2_q, s3_q;
    logic [N-1:0] s1_d, s2_d, s3_d;

    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
        // Only the second and third stages are compared; the first may be metastable
        edges = (rise_sel & s2_q & ~s3_q) | (~rise_sel & ~s2_q & s3_q);
    end

    // Idle level is high so a reset does not fake a falling edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/piu_core.sv ====
// Priority interrupt unit with latch, mask, active register and nesting stack
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module piu_core
    import piu_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port
    input wire piu_bus_req_t bus_req,
    output logic [DATA_W-1:0] rdata,
    // Interrupt inputs and request line
    input wire logic [NUM_IRQ-1:0] interrupt_inputs,
    output logic irq_req_n,
    // Unit event interrupt
    output logic irq
);
    function automatic logic [LVL_W-1:0] f_level(input logic [NUM_IRQ-1:0] v);
        logic [LVL_W-1:0] l;
        l = LVL_NONE;
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (v[i]) begin
                l = LVL_W'(i + 1);
            end
        end
        return l;
    endfunction

    function automatic logic [NUM_IRQ-1:0] f_onehot(input logic [LVL_W-1:0] l);
        logic [NUM_IRQ-1:0] v;
        v = '0;
        if (l != LVL_NONE) begin
            v[l - LVL_W'(1)] = 1'b1;
        end
        return v;
    endfunction

    piu_ctrl_t ctrl_q, ctrl_d;
    logic [NUM_IRQ-1:0] mask_q, mask_d;
    logic [NUM_IRQ-1:0] latch_q, latch_d;
    logic [NUM_IRQ-1:0] air_q, air_d;
    logic req_q, req_d;
    logic read_done_q, read_done_d;
    logic [LVL_W-1:0] stk_q [DEPTH];
    logic [LVL_W-1:0] stk_d [DEPTH];
    logic [SP_W-1:0] sp_q, sp_d;
    logic [NUM_EV-1:0] stat_q, stat_d;
    logic [NUM_EV-1:0] imask_q, imask_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [NUM_EV-1:0] ev;
    logic [NUM_IRQ-1:0] edges, rise_sel, pend;
    logic [LVL_W-1:0] svc, thr, top;
    logic rd_air, wr_air;

    assign rise_sel = {ctrl_q.edge_select_four, ctrl_q.edge_select_three, 3'h0};

    piu_edge_detect #(
        .N(NUM_IRQ)
    ) u_edge (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pins(interrupt_inputs),
        .rise_sel(rise_sel),
        .edges(edges)
    );

    assign rd_air = bus_req.rd && (bus_req.addr == OFS_ACTIVE);
    assign wr_air = bus_req.wr && (bus_req.addr == OFS_ACTIVE);

    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        latch_d = latch_q;
        air_d = air_q;
        req_d = req_q;
        read_done_d = read_done_q;
        stk_d = stk_q;
        sp_d = sp_q;
        imask_d = imask_q;
        ev = '0;
        // Level being serviced sits on top of the stack
        svc = (sp_q == '0) ? LVL_NONE : stk_q[sp_q - SP_W'(1)];
        top = f_level(air_q);
        thr = (air_q != '0) ? top : svc;
        // No input is pending outside interrupt mode
        pend = ctrl_q.port_c_interrupt_mode ? (latch_q & mask_q) : '0;

        if (bus_req.wr && bus_req.addr == OFS_CTRL) begin
            ctrl_d = piu_ctrl_t'(bus_req.wdata[$bits(piu_ctrl_t)-1:0]);
        end
        if (bus_req.wr && bus_req.addr == OFS_MASK) begin
            mask_d = bus_req.wdata[NUM_IRQ-1:0];
        end
        if (bus_req.wr && bus_req.addr == OFS_IMASK) begin
            imask_d = bus_req.wdata[NUM_EV-1:0];
        end
        if (bus_req.wr && bus_req.addr == OFS_PORTC && ctrl_q.port_c_interrupt_mode) begin
            latch_d = latch_d & bus_req.wdata[NUM_IRQ-1:0];
        end

        if (wr_air) begin
            air_d = '0;
            read_done_d = 1'b0;
            if (sp_q != '0) begin
                sp_d = sp_q - SP_W'(1);
            end else begin
                ev[EV_UNDERFLOW] = 1'b1;
            end
        end else if (rd_air) begin
            // Clearing by and-not rather than xor keeps a latch bit already cleared from coming back
            latch_d = latch_d & ~air_q;
            req_d = 1'b0;
            read_done_d = 1'b1;
            if (sp_q < SP_W'(DEPTH)) begin
                stk_d[sp_q] = top;
                sp_d = sp_q + SP_W'(1);
            end else begin
                ev[EV_OVERFLOW] = 1'b1;
            end
        end else if (ctrl_q.priority_select) begin
            // Only a strictly higher level than the active or serviced one gets through
            if (f_level(pend) > thr) begin
                air_d = f_onehot(f_level(pend));
                req_d = 1'b1;
                ev[EV_LOAD] = 1'b1;
            end
        end else if (!read_done_q && (pend & ~air_q) != '0) begin
            // Unprioritized: gather every new unmasked latched bit until software reads
            air_d = air_q | pend;
            req_d = 1'b1;
            ev[EV_LOAD] = 1'b1;
        end

        // A new edge wins over any clear in the same cycle
        latch_d = latch_d | edges;

        stat_d = stat_q;
        if (bus_req.wr && bus_req.addr == OFS_ISTAT) begin
            stat_d = stat_q & ~bus_req.wdata[NUM_EV-1:0];
        end
        stat_d = stat_d | ev;

        rdata_d = '0;
        if (bus_req.rd) begin
            if (bus_req.addr == OFS_CTRL) begin
                rdata_d = DATA_W'(ctrl_q);
            end else if (bus_req.addr == OFS_ACTIVE) begin
                rdata_d = DATA_W'(air_q);
            end else if (bus_req.addr == OFS_MASK) begin
                rdata_d = DATA_W'(mask_q);
            end else if (bus_req.addr == OFS_PORTC) begin
                rdata_d = DATA_W'(latch_q);
                rdata_d[PORTC_REQ_BIT] = ~req_q;
            end else if (bus_req.addr == OFS_ISTAT) begin
                rdata_d = DATA_W'(stat_q);
            end else if (bus_req.addr == OFS_IMASK) begin
                rdata_d = DATA_W'(imask_q);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RST;
            mask_q <= MASK_RST;
            latch_q <= '0;
            air_q <= '0;
            req_q <= 1'b0;
            read_done_q <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                stk_q[i] <= LVL_NONE;
            end
            sp_q <= '0;
            stat_q <= '0;
            imask_q <= IMASK_RST;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            latch_q <= latch_d;
            air_q <= air_d;
            req_q <= req_d;
            read_done_q <= read_done_d;
            stk_q <= stk_d;
            sp_q <= sp_d;
            stat_q <= stat_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign irq_req_n = ~req_q;
    assign irq = |(stat_q & imask_q);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_prio_onehot: assert property (ctrl_q.priority_select |-> $onehot0(air_q))
        else $error("more than one active bit in prioritized mode");
    a_load_requests: assert property ($rose(|air_q) |-> req_q && !irq_req_n)
        else $error("active bit set without request");
    a_read_release: assert property (rd_air && !wr_air |=> !req_q && (latch_q & $past(air_q) & ~$past(edges)) == '0)
        else $error("read did not release request or clear latch");
    a_write_clears: assert property (wr_air |=> air_q == '0)
        else $error("write did not clear active register");
    a_push_depth: assert property (rd_air && !wr_air && sp_q < SP_W'(DEPTH) |=> sp_q == $past(sp_q) + SP_W'(1))
        else $error("read did not push stack");
    a_pull_depth: assert property (wr_air && sp_q != '0 |=> sp_q == $past(sp_q) - SP_W'(1))
        else $error("write did not pull stack");
    a_mask_blocks: assert property (ctrl_q.priority_select && $rose(req_q) |-> (air_q & ~$past(mask_q)) == '0)
        else $error("masked input reached active register");
    a_highest_first: assert property (ctrl_q.priority_select && $past(ctrl_q.priority_select) && $rose(req_q)
        |-> air_q == f_onehot(f_level($past(pend))))
        else $error("active bit is not the highest pending input");
    a_lower_waits: assert property (ctrl_q.priority_select && air_q != '0 && !rd_air && !wr_air
        && f_level(pend) <= f_level(air_q) |=> $stable(air_q))
        else $error("lower input disturbed active register");
endmodule
`default_nettype wire

// ==== dv/piu_host.sv ====
// Host processor model driving the register port of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module piu_host
    import piu_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Register port
    output piu_bus_req_t bus_req,
    input wire logic [DATA_W-1:0] rdata
);
    initial bus_req = '0;

    // Callers read the active register only to answer a request, as each read pushes the stack
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] dat);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 dat = rdata;
    endtask

    // Callers write the active register only to end a service, as each write pulls the stack
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dat);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/priority_interrupt_unit_test.sv ====
// Self-checking testbench of the priority interrupt unit
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_unit_test;
    import piu_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [NUM_IRQ-1:0] pins = 5'h1f;
    piu_bus_req_t bus_req;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] d;
    logic irq_req_n;
    logic irq;
    logic [NUM_IRQ-1:0] m;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 13;
    int b;

    always #5 clk_sys = ~clk_sys;

    piu_host host (.clk_sys(clk_sys), .bus_req(bus_req), .rdata(rdata));

    piu_core dut (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .bus_req(bus_req),
        .rdata(rdata),
        .interrupt_inputs(pins),
        .irq_req_n(irq_req_n),
        .irq(irq)
    );

    task automatic test_done();
        $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run needs well under this many cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask

    // Pins idle high; a pulse gives a fall, then a rise two cycles later
    task automatic pulse(input logic [NUM_IRQ-1:0] p);
        @(posedge clk_sys);
        pins <= ~p;
        repeat (2) @(posedge clk_sys);
        pins <= 5'h1f;
    endtask

    // Sample 1 ns past each edge so the request flop has settled
    task automatic wait_req(input logic e);
        for (int i = 0; i < 12 && irq_req_n !== e; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("irq_req_n", {7'h00, e}, {7'h00, irq_req_n});
    endtask

    // Request line must still be released ten cycles later
    task automatic quiet();
        repeat (10) @(posedge clk_sys);
        #1 chk("irq_req_n", 8'h01, {7'h00, irq_req_n});
    endtask

    // Answer a request: read the active register, expect the line back high
    task automatic serve(input logic [7:0] e);
        wait_req(1'b0);
        host.rd(OFS_ACTIVE, d);
        chk("active", e, d);
        chk("irq_req_n", 8'h01, {7'h00, irq_req_n});
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1 chk("irq_req_n", 8'h01, {7'h00, irq_req_n});
        host.rd(OFS_PORTC, d);
        chk("portc", 8'h20, d);
        host.rd(OFS_MASK, d);
        chk("mask", 8'h00, d);
        host.rd(3'h7, d);
        chk("unmapped", 8'h00, d);
        host.wr(OFS_MASK, 8'h1f);
        host.wr(OFS_IMASK, 8'h01);
        host.wr(OFS_CTRL, 8'h03);
        pulse(5'h02);
        serve(8'h02);
        host.wr(OFS_ACTIVE, 8'h00);
        quiet();
        // Pre-emption of a lower service by a higher input
        pulse(5'h02);
        serve(8'h02);
        pulse(5'h04);
        serve(8'h04);
        host.wr(OFS_ACTIVE, 8'h00);
        quiet();
        host.wr(OFS_ACTIVE, 8'h00);
        // Two inputs at once: higher wins, lower waits for the completion write
        pulse(5'h03);
        serve(8'h02);
        quiet();
        host.wr(OFS_ACTIVE, 8'h00);
        serve(8'h01);
        host.wr(OFS_ACTIVE, 8'h00);
        // Input three on rising edge, input four on falling edge
        host.wr(OFS_CTRL, 8'h07);
        pulse(5'h08);
        serve(8'h08);
        host.wr(OFS_ACTIVE, 8'h00);
        pulse(5'h10);
        serve(8'h10);
        host.wr(OFS_ACTIVE, 8'h00);
        // Without priority both bits transfer together
        host.wr(OFS_CTRL, 8'h01);
        pulse(5'h03);
        serve(8'h03);
        host.wr(OFS_ACTIVE, 8'h00);
        host.wr(OFS_CTRL, 8'h03);
        repeat (8) begin
            m = NUM_IRQ'($random(seed));
            b = {$random(seed)} % NUM_IRQ;
            host.wr(OFS_MASK, {3'h0, m});
            pulse(5'h01 << b);
            if (m[b]) begin
                serve(8'h01 << b);
                host.wr(OFS_ACTIVE, 8'h00);
            end else begin
                quiet();
                host.rd(OFS_PORTC, d);
                chk("latch", 8'h20 | (8'h01 << b), d);
                host.wr(OFS_PORTC, ~(8'h01 << b));
                host.rd(OFS_PORTC, d);
                chk("latch", 8'h20, d);
            end
        end
        // Load events were flagged; clearing the flag drops the event line
        chk("irq", 8'h01, {7'h00, irq});
        host.wr(OFS_ISTAT, 8'h01);
        @(posedge clk_sys);
        #1 chk("irq", 8'h00, {7'h00, irq});
        // Reset in mid-service: a stale level or stack entry would block input zero afterwards
        host.wr(OFS_MASK, 8'h1f);
        pulse(5'h02);
        serve(8'h02);
        pulse(5'h01);
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1 chk("irq_req_n", 8'h01, {7'h00, irq_req_n});
        host.rd(OFS_PORTC, d);
        chk("portc", 8'h20, d);
        host.wr(OFS_MASK, 8'h1f);
        host.wr(OFS_CTRL, 8'h03);
        pulse(5'h01);
        serve(8'h01);
        host.wr(OFS_ACTIVE, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
